// ===== fifo_read_port_control_tb.sv
// Testbench for the FIFO read port controller
`timescale 1ns/1ps
`default_nettype none
module fifo_read_port_control_tb;
  logic sys_clk, nrst, full_reset_n, partial_clear_n, read_async_strap;
  logic [1:0] out_width_strap;
  logic read_select_n, output_enable_n, rewind_request, mark_request;
  logic offset_access_sel_n, wr_valid, wr_ready_q, read_data_oe_q, empty_flag_n_q;
  logic [35:0] wr_data, read_data_out_q;
  logic read_clk_strobe, read_enable_n, serial_clk, offset_shift_enable_n;
  logic fallthrough_sel_serial_in, saw_low;
  int n_mismatch, num_checks, cycles, i;
  logic [35:0] wd [3] = '{36'h123456789, 36'hABCDEF012, 36'h3C3C3C3C3};
  logic [31:0] offs = 32'h1234ABCD;
  logic [35:0] wa = 36'h987654321;

  frp_read_port i_frp_read_port (.sys_clk(sys_clk), .nrst(nrst),
    .full_reset_n(full_reset_n), .partial_clear_n(partial_clear_n),
    .read_async_strap(read_async_strap), .out_width_strap(out_width_strap),
    .read_clk_strobe(read_clk_strobe), .read_enable_n(read_enable_n),
    .read_select_n(read_select_n), .output_enable_n(output_enable_n),
    .rewind_request(rewind_request), .mark_request(mark_request),
    .offset_access_sel_n(offset_access_sel_n), .serial_clk(serial_clk),
    .offset_shift_enable_n(offset_shift_enable_n),
    .fallthrough_sel_serial_in(fallthrough_sel_serial_in), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready_q(wr_ready_q), .read_data_out_q(read_data_out_q),
    .read_data_oe_q(read_data_oe_q), .empty_flag_n_q(empty_flag_n_q));
  frp_host_model i_frp_host_model (.sys_clk(sys_clk), .read_clk_strobe(read_clk_strobe),
    .read_enable_n(read_enable_n), .serial_clk(serial_clk),
    .offset_shift_enable_n(offset_shift_enable_n),
    .fallthrough_sel_serial_in(fallthrough_sel_serial_in));

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (rewind_request && empty_flag_n_q === 1'h0) saw_low <= 1'h1;
    if (cycles == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [35:0] exp);
    i_frp_host_model.read_edge();
    cyc(4);
    check(read_data_out_q, exp);
  endtask
  task automatic write_word(input logic [35:0] d);
    int k;
    k = 0;
    wr_valid <= 1'h1;
    wr_data <= d;
    do begin
      @(negedge sys_clk);
      k++;
    end while (wr_ready_q !== 1'h1 && k < 100);
    @(posedge sys_clk);
    wr_valid <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic full_reset(input logic am, input logic [1:0] w);
    full_reset_n <= 1'h0;
    read_async_strap <= am;
    out_width_strap <= w;
    cyc(8);
    full_reset_n <= 1'h1;
    cyc(8);
  endtask

  initial begin
    nrst = 1'h0; full_reset_n = 1'h0; partial_clear_n = 1'h1; read_async_strap = 1'h0;
    out_width_strap = 2'h0; read_select_n = 1'h0; output_enable_n = 1'h0;
    rewind_request = 1'h0; mark_request = 1'h0; offset_access_sel_n = 1'h1;
    wr_valid = 1'h0; wr_data = 36'h0; saw_low = 1'h0;
    n_mismatch = 0; num_checks = 0; cycles = 0;
    cyc(8);
    nrst <= 1'h1;
    full_reset(1'h0, 2'h0);
    check(empty_flag_n_q, 36'h0);
    rd(36'h0);
    for (i = 0; i < 3; i++) write_word(wd[i]);
    cyc(4);
    check(empty_flag_n_q, 36'h1);
    check(read_data_oe_q, 36'h1);
    rd(wd[0]);
    mark_request <= 1'h1;
    cyc(4);
    mark_request <= 1'h0;
    read_select_n <= 1'h1;
    cyc(4);
    check(read_data_oe_q, 36'h0);
    rd(wd[0]);
    read_select_n <= 1'h0;
    rd(wd[1]);
    rewind_request <= 1'h1;
    i_frp_host_model.read_edge();
    rewind_request <= 1'h0;
    cyc(4);
    check(saw_low, 36'h1);
    rd(wd[1]);
    rd(wd[2]);
    for (i = 31; i >= 0; i--) i_frp_host_model.shift_bit(offs[i]);
    i_frp_host_model.strap(1'h0);
    offset_access_sel_n <= 1'h0;
    rd({20'h0, offs[31:16]});
    rd({20'h0, offs[15:0]});
    partial_clear_n <= 1'h0;
    read_select_n <= 1'h1;
    cyc(6);
    check(read_data_oe_q, 36'h1);
    check(read_data_out_q, 36'h0);
    output_enable_n <= 1'h1;
    cyc(6);
    check(read_data_oe_q, 36'h0);
    output_enable_n <= 1'h0;
    partial_clear_n <= 1'h1;
    read_select_n <= 1'h0;
    cyc(8);
    check(empty_flag_n_q, 36'h0);
    rd({20'h0, offs[31:16]});
    offset_access_sel_n <= 1'h1;
    full_reset(1'h1, 2'h1);
    write_word(wa);
    cyc(4);
    rd({18'h0, wa[17:0]});
    rd({18'h0, wa[35:18]});
    i_frp_host_model.strap(1'h1);
    full_reset(1'h0, 2'h2);
    write_word(wa);
    cyc(4);
    check(empty_flag_n_q, 36'h0);
    check(read_data_out_q, {27'h0, wa[8:0]});
    rd({27'h0, wa[17:9]});
    rd({27'h0, wa[26:18]});
    rd({27'h0, wa[35:27]});
    i_frp_host_model.read_edge();
    cyc(4);
    check(empty_flag_n_q, 36'h1);
    check(read_data_out_q, {27'h0, wa[35:27]});
    report_and_stop();
  end
endmodule
bind frp_read_port frp_read_port_props i_frp_read_port_props (.sys_clk(sys_clk),
  .nrst(nrst), .full_reset_n(full_reset_n), .partial_clear_n(partial_clear_n),
  .read_async_strap(read_async_strap),
  .fallthrough_sel_serial_in(fallthrough_sel_serial_in),
  .read_clk_strobe(read_clk_strobe), .read_select_n(read_select_n),
  .output_enable_n(output_enable_n), .rewind_request(rewind_request),
  .wr_ready_q(wr_ready_q), .read_data_out_q(read_data_out_q),
  .read_data_oe_q(read_data_oe_q), .empty_flag_n_q(empty_flag_n_q));
`default_nettype wire

// ===== frp_host_model.sv
// Host model: read clock, read enable and serial offset loading
`timescale 1ns/1ps
`default_nettype none
module frp_host_model (
  // Clock
  input  wire logic sys_clk,
  // Read side
  output logic      read_clk_strobe,
  output logic      read_enable_n,
  // Serial load
  output logic      serial_clk,
  output logic      offset_shift_enable_n,
  output logic      fallthrough_sel_serial_in
);
  initial begin
    read_clk_strobe = 1'h0;
    read_enable_n = 1'h0;
    serial_clk = 1'h0;
    offset_shift_enable_n = 1'h1;
    fallthrough_sel_serial_in = 1'h0;
  end
  // One read clock period of 8 system cycles, still between reads
  task automatic read_edge();
    read_clk_strobe <= 1'h1;
    repeat (4) @(posedge sys_clk);
    read_clk_strobe <= 1'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Bit set up before the serial clock rises, inverted once held long enough
  task automatic shift_bit(input logic b);
    offset_shift_enable_n <= 1'h0;
    fallthrough_sel_serial_in <= b;
    repeat (2) @(posedge sys_clk);
    serial_clk <= 1'h1;
    repeat (4) @(posedge sys_clk);
    serial_clk <= 1'h0;
    fallthrough_sel_serial_in <= !b;
    repeat (2) @(posedge sys_clk);
  endtask
  // Stop shifting and present the mode strap
  task automatic strap(input logic ft);
    offset_shift_enable_n <= 1'h1;
    fallthrough_sel_serial_in <= ft;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ===== frp_mem.sv
// Word storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module frp_mem (
  // Clock
  input  wire logic                          clk,
  // Write side
  input  wire logic                          wr_en,
  input  wire logic [frp_pkg::ADDR_W-1:0]    wr_addr,
  input  wire logic [frp_pkg::DATA_W-1:0]    wr_data,
  // Read side
  input  wire logic [frp_pkg::ADDR_W-1:0]    rd_addr,
  output logic      [frp_pkg::DATA_W-1:0]    rd_data_q
);

  logic [frp_pkg::DATA_W-1:0] mem [frp_pkg::DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data_q <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ===== frp_pkg.sv
// Constants, types and helper functions for the FIFO read port controller
package frp_pkg;

  // Storage geometry
  localparam int ADDR_W = 16;
  localparam int PTR_W  = 17;
  localparam int DATA_W = 36;
  localparam int OFFS_W = 16;
  localparam int DEPTH  = 65536;
  localparam logic [PTR_W-1:0] DEPTH_CNT = 17'h10000;

  // Synchroniser bank layout
  localparam int SYNC_W      = 15;
  localparam int PIN_RCLK    = 0;
  localparam int PIN_SCLK    = 1;
  localparam int PIN_REN_N   = 2;
  localparam int PIN_RSEL_N  = 3;
  localparam int PIN_REWIND  = 4;
  localparam int PIN_MARK    = 5;
  localparam int PIN_SEN_N   = 6;
  localparam int PIN_FALLTHROUGH_SEL_SERIAL_IN = 7;
  localparam int PIN_LD_N    = 8;
  localparam int PIN_FRST_N  = 9;
  localparam int PIN_PRST_N  = 10;
  localparam int PIN_OE_N    = 11;
  localparam int PIN_ASYNC   = 12;
  localparam int PIN_WSEL_LO = 13;
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h0D4C;

  // Offset reset values (loaded during full reset)
  localparam logic [OFFS_W-1:0] EMPTY_OFFS_RST = 16'h007F;
  localparam logic [OFFS_W-1:0] FULL_OFFS_RST  = 16'h007F;

  // Output width selection
  typedef enum logic [1:0] {
    FRP_W36 = 2'h0,
    FRP_W18 = 2'h1,
    FRP_W9  = 2'h3
  } frp_width_t;

  // Memory fetch sequencer
  typedef enum logic {
    FRP_IDLE  = 1'b0,
    FRP_FETCH = 1'b1
  } frp_fetch_t;

  // Strap code to width
  function automatic frp_width_t width_decode(input logic [1:0] code);
    unique case (code)
      2'h0:    width_decode = FRP_W36;
      2'h1:    width_decode = FRP_W18;
      default: width_decode = FRP_W9;
    endcase
  endfunction

  // Index of the last lane of a word
  function automatic logic [1:0] last_lane(input frp_width_t wd);
    unique case (wd)
      FRP_W36: last_lane = 2'h0;
      FRP_W18: last_lane = 2'h1;
      default: last_lane = 2'h3;
    endcase
  endfunction

  // One lane of a word, low lane first, upper lines zero
  function automatic logic [DATA_W-1:0] lane_slice(input logic [DATA_W-1:0] w,
                                                  input logic [1:0]        lane,
                                                  input frp_width_t        wd);
    unique case (wd)
      FRP_W36: lane_slice = w;
      FRP_W18: lane_slice = lane[0] ? {18'h00000, w[35:18]} : {18'h00000, w[17:0]};
      default: begin
        unique case (lane)
          2'h0: lane_slice = {27'h0000000, w[8:0]};
          2'h1: lane_slice = {27'h0000000, w[17:9]};
          2'h2: lane_slice = {27'h0000000, w[26:18]};
          2'h3: lane_slice = {27'h0000000, w[35:27]};
        endcase
      end
    endcase
  endfunction

endpackage

// ===== frp_read_port.sv
// FIFO read port: pointers, output register, retransmit and offset loading
//
// Functional notes
// - Partial reset zeroes pointers and output register
// - Partial reset keeps modes, method and offsets
// - Output 36, 18 or 9 bits wide
// - Enabled read edge reads word or offset
// - Offset select low presents offset registers in sync mode only
// - Async mode: each strobe rising edge reads
// - Read select sampled, gates reads and drivers
// - During resets select ignored, enable drives
// - Rewind resets read pointer, flags empty
// - Rewind jumps to marked location if set
// - Serial clock edge shifts bit into offsets
// - After full reset, mode pin is serial input
// - Mark records current read pointer
`timescale 1ns/1ps
`default_nettype none
module frp_read_port (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  // Resets from pins
  input  wire logic                        full_reset_n,
  input  wire logic                        partial_clear_n,
  // Configuration straps, caught during full reset
  input  wire logic                        read_async_strap,
  input  wire logic [1:0]                  out_width_strap,
  // Read port pins
  input  wire logic                        read_clk_strobe,
  input  wire logic                        read_enable_n,
  input  wire logic                        read_select_n,
  input  wire logic                        output_enable_n,
  input  wire logic                        rewind_request,
  input  wire logic                        mark_request,
  input  wire logic                        offset_access_sel_n,
  // Serial offset loading pins
  input  wire logic                        serial_clk,
  input  wire logic                        offset_shift_enable_n,
  input  wire logic                        fallthrough_sel_serial_in,
  // Write side, same clock domain
  input  wire logic                        wr_valid,
  input  wire logic [frp_pkg::DATA_W-1:0]  wr_data,
  output logic                             wr_ready_q,
  // Read data and flags
  output logic      [frp_pkg::DATA_W-1:0]  read_data_out_q,
  output logic                             read_data_oe_q,
  output logic                             empty_flag_n_q
);

  // Synchronised pins
  logic [frp_pkg::SYNC_W-1:0] pins_s;
  logic                       rclk_s;
  logic                       sclk_s;
  logic                       ren_n_s;
  logic                       rsel_n_s;
  logic                       rewind_s;
  logic                       mark_s;
  logic                       sen_n_s;
  logic                       si_s;
  logic                       ld_n_s;
  logic                       frst_n_s;
  logic                       prst_n_s;
  logic                       oe_n_s;
  logic                       async_s;
  logic [1:0]                 wsel_s;

  frp_sync #(
    .W       (frp_pkg::SYNC_W),
    .RST_VAL (frp_pkg::SYNC_RST)
  ) u_sync (
    .clk      (sys_clk),
    .rst_n    (nrst),
    .async_in ({out_width_strap, read_async_strap, output_enable_n, partial_clear_n,
                full_reset_n, offset_access_sel_n, fallthrough_sel_serial_in,
                offset_shift_enable_n, mark_request, rewind_request, read_select_n,
                read_enable_n, serial_clk, read_clk_strobe}),
    .sync_out (pins_s)
  );

  assign rclk_s   = pins_s[frp_pkg::PIN_RCLK];
  assign sclk_s   = pins_s[frp_pkg::PIN_SCLK];
  assign ren_n_s  = pins_s[frp_pkg::PIN_REN_N];
  assign rsel_n_s = pins_s[frp_pkg::PIN_RSEL_N];
  assign rewind_s = pins_s[frp_pkg::PIN_REWIND];
  assign mark_s   = pins_s[frp_pkg::PIN_MARK];
  assign sen_n_s  = pins_s[frp_pkg::PIN_SEN_N];
  assign si_s     = pins_s[frp_pkg::PIN_FALLTHROUGH_SEL_SERIAL_IN];
  assign ld_n_s   = pins_s[frp_pkg::PIN_LD_N];
  assign frst_n_s = pins_s[frp_pkg::PIN_FRST_N];
  assign prst_n_s = pins_s[frp_pkg::PIN_PRST_N];
  assign oe_n_s   = pins_s[frp_pkg::PIN_OE_N];
  assign async_s  = pins_s[frp_pkg::PIN_ASYNC];
  assign wsel_s   = pins_s[frp_pkg::PIN_WSEL_LO +: 2];

  // State
  logic                              rclk_prev_q;
  logic                              sclk_prev_q;
  logic                              mark_prev_q;
  logic                              first_word_fallthrough_mode_q;
  logic                              async_q;
  logic                              serial_meth_q;
  frp_pkg::frp_width_t               width_q;
  logic [frp_pkg::OFFS_W-1:0]        empty_offs_q;
  logic [frp_pkg::OFFS_W-1:0]        full_offs_q;
  logic                              offs_tog_q;
  logic [frp_pkg::PTR_W-1:0]         wptr_q;
  logic [frp_pkg::PTR_W-1:0]         wptr_d;
  logic [frp_pkg::PTR_W-1:0]         rptr_q;
  logic [frp_pkg::PTR_W-1:0]         rptr_d;
  logic [frp_pkg::PTR_W-1:0]         mark_ptr_q;
  logic                              mark_valid_q;
  frp_pkg::frp_fetch_t               fetch_q;
  logic [frp_pkg::DATA_W-1:0]        word_q;
  logic [1:0]                        lane_q;
  logic                              first_word_fallthrough_mode_valid_q;
  logic [frp_pkg::DATA_W-1:0]        mem_rd_data;

  // Events
  logic                              in_full_rst;
  logic                              in_rst;
  logic                              rclk_rise;
  logic                              sclk_rise;
  logic                              read_take;
  logic                              rewind_evt;
  logic                              offset_read;
  logic                              fifo_read;
  logic                              fetch_issue;
  logic                              wr_accept;
  logic [frp_pkg::PTR_W-1:0]         count;
  logic [frp_pkg::PTR_W-1:0]         count_d;
  logic                              empty;
  logic [1:0]                        last;

  assign in_full_rst = !frst_n_s;
  assign in_rst      = !frst_n_s || !prst_n_s;
  assign rclk_rise   = rclk_s && !rclk_prev_q;
  assign sclk_rise   = sclk_s && !sclk_prev_q;
  assign count       = wptr_q - rptr_q;
  assign empty       = (count == '0);
  assign last        = frp_pkg::last_lane(width_q);
  assign wr_accept   = wr_valid && wr_ready_q;
  assign rewind_evt  = rclk_rise && rewind_s && !in_rst;
  // Selected, enabled read edge; async mode ignores the enable
  assign read_take   = rclk_rise && !rsel_n_s && (async_q || !ren_n_s) && !in_rst;
  assign offset_read = read_take && !rewind_evt && !async_q && !ld_n_s;
  assign fifo_read   = read_take && !rewind_evt && !offset_read;
  // Standard mode fetches on demand; fall-through fetches ahead
  assign fetch_issue = !in_rst && !rewind_evt && (fetch_q == frp_pkg::FRP_IDLE) && !empty
                       && (first_word_fallthrough_mode_q ? !first_word_fallthrough_mode_valid_q : (fifo_read && lane_q == 2'h0));

  // Edge history
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rclk_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      mark_prev_q <= 1'b0;
    end else begin
      rclk_prev_q <= rclk_s;
      sclk_prev_q <= sclk_s;
      mark_prev_q <= mark_s;
    end
  end

  // Configuration captured only in full reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_word_fallthrough_mode_q        <= 1'b0;
      async_q       <= 1'b0;
      serial_meth_q <= 1'b1;
      width_q       <= frp_pkg::FRP_W36;
    end else if (in_full_rst) begin
      first_word_fallthrough_mode_q        <= si_s && !async_s;
      async_q       <= async_s;
      serial_meth_q <= ld_n_s;
      width_q       <= frp_pkg::width_decode(wsel_s);
    end
  end

  // Offset registers and serial shift chain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      empty_offs_q <= frp_pkg::EMPTY_OFFS_RST;
      full_offs_q  <= frp_pkg::FULL_OFFS_RST;
    end else if (in_full_rst) begin
      empty_offs_q <= frp_pkg::EMPTY_OFFS_RST;
      full_offs_q  <= frp_pkg::FULL_OFFS_RST;
    end else if (sclk_rise && !sen_n_s && serial_meth_q) begin
      empty_offs_q <= {empty_offs_q[frp_pkg::OFFS_W-2:0], full_offs_q[frp_pkg::OFFS_W-1]};
      full_offs_q  <= {full_offs_q[frp_pkg::OFFS_W-2:0], si_s};
    end
  end

  // Pointer next values
  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    if (in_rst) begin
      wptr_d = '0;
      rptr_d = '0;
    end else begin
      if (wr_accept) begin
        wptr_d = wptr_q + 17'h00001;
      end
      if (rewind_evt) begin
        rptr_d = mark_valid_q ? mark_ptr_q : '0;
      end else if (fetch_issue) begin
        rptr_d = rptr_q + 17'h00001;
      end
    end
  end

  assign count_d = wptr_d - rptr_d;

  // Pointers and write acceptance
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wptr_q     <= '0;
      rptr_q     <= '0;
      wr_ready_q <= 1'b0;
    end else begin
      wptr_q     <= wptr_d;
      rptr_q     <= rptr_d;
      wr_ready_q <= !in_rst && (count_d < frp_pkg::DEPTH_CNT);
    end
  end

  // Mark for retransmit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mark_ptr_q   <= '0;
      mark_valid_q <= 1'b0;
    end else if (in_rst) begin
      mark_ptr_q   <= '0;
      mark_valid_q <= 1'b0;
    end else if (mark_s && !mark_prev_q) begin
      mark_ptr_q   <= rptr_q;
      mark_valid_q <= 1'b1;
    end
  end

  // Fetch sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_q <= frp_pkg::FRP_IDLE;
    end else if (in_rst || rewind_evt) begin
      fetch_q <= frp_pkg::FRP_IDLE;
    end else begin
      unique case (fetch_q)
        frp_pkg::FRP_IDLE:  fetch_q <= fetch_issue ? frp_pkg::FRP_FETCH : frp_pkg::FRP_IDLE;
        frp_pkg::FRP_FETCH: fetch_q <= frp_pkg::FRP_IDLE;
      endcase
    end
  end

  frp_mem u_mem (
    .clk       (sys_clk),
    .wr_en     (wr_accept),
    .wr_addr   (wptr_q[frp_pkg::ADDR_W-1:0]),
    .wr_data   (wr_data),
    .rd_addr   (rptr_q[frp_pkg::ADDR_W-1:0]),
    .rd_data_q (mem_rd_data)
  );

  // Output register, lane position and fall-through valid
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      read_data_out_q <= '0;
      word_q          <= '0;
      lane_q          <= 2'h0;
      first_word_fallthrough_mode_valid_q    <= 1'b0;
      offs_tog_q      <= 1'b0;
    end else if (in_rst) begin
      read_data_out_q <= '0;
      word_q          <= '0;
      lane_q          <= 2'h0;
      first_word_fallthrough_mode_valid_q    <= 1'b0;
      offs_tog_q      <= 1'b0;
    end else if (rewind_evt) begin
      lane_q       <= 2'h0;
      first_word_fallthrough_mode_valid_q <= 1'b0;
    end else if (fetch_q == frp_pkg::FRP_FETCH) begin
      word_q          <= mem_rd_data;
      read_data_out_q <= frp_pkg::lane_slice(mem_rd_data, 2'h0, width_q);
      lane_q          <= (first_word_fallthrough_mode_q || last == 2'h0) ? 2'h0 : 2'h1;
      first_word_fallthrough_mode_valid_q    <= first_word_fallthrough_mode_q;
    end else if (offset_read) begin
      read_data_out_q <= {20'h00000, offs_tog_q ? full_offs_q : empty_offs_q};
      offs_tog_q      <= !offs_tog_q;
    end else if (fifo_read) begin
      if (first_word_fallthrough_mode_q) begin
        if (first_word_fallthrough_mode_valid_q && lane_q == last) begin
          lane_q       <= 2'h0;
          first_word_fallthrough_mode_valid_q <= 1'b0;
        end else if (first_word_fallthrough_mode_valid_q) begin
          lane_q          <= lane_q + 2'h1;
          read_data_out_q <= frp_pkg::lane_slice(word_q, lane_q + 2'h1, width_q);
        end
      end else if (lane_q != 2'h0) begin
        read_data_out_q <= frp_pkg::lane_slice(word_q, lane_q, width_q);
        lane_q          <= (lane_q == last) ? 2'h0 : lane_q + 2'h1;
      end
    end
  end

  // Output driver enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      read_data_oe_q <= 1'b0;
    end else if (in_rst) begin
      read_data_oe_q <= !oe_n_s;
    end else begin
      read_data_oe_q <= !oe_n_s && !rsel_n_s;
    end
  end

  // Empty flag, or output-ready in fall-through mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      empty_flag_n_q <= 1'b0;
    end else if (in_rst || rewind_evt) begin
      empty_flag_n_q <= first_word_fallthrough_mode_q;
    end else if (first_word_fallthrough_mode_q) begin
      empty_flag_n_q <= !first_word_fallthrough_mode_valid_q;
    end else begin
      empty_flag_n_q <= !(empty && lane_q == 2'h0 && fetch_q == frp_pkg::FRP_IDLE);
    end
  end

endmodule
`default_nettype wire

// ===== frp_read_port_properties.sv
// Port-level checks for the FIFO read port controller
`timescale 1ns/1ps
`default_nettype none
module frp_read_port_props (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       nrst,
  // Pins
  input wire logic                       full_reset_n,
  input wire logic                       partial_clear_n,
  input wire logic                       read_async_strap,
  input wire logic                       fallthrough_sel_serial_in,
  input wire logic                       read_clk_strobe,
  input wire logic                       read_select_n,
  input wire logic                       output_enable_n,
  input wire logic                       rewind_request,
  // Outputs
  input wire logic                       wr_ready_q,
  input wire logic [frp_pkg::DATA_W-1:0] read_data_out_q,
  input wire logic                       read_data_oe_q,
  input wire logic                       empty_flag_n_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic ft_q;
  // Fall-through mode as strapped during full reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ft_q <= 1'h0;
    end else if (!full_reset_n) begin
      ft_q <= fallthrough_sel_serial_in && !read_async_strap;
    end
  end
  sequence run_s;
    full_reset_n && partial_clear_n;
  endsequence
  sequence rewind_s;
    (($rose(read_clk_strobe) && rewind_request) and run_s) ##1 rewind_request;
  endsequence
  part_clear_a: assert property ((!partial_clear_n)[*4] |=>
    read_data_out_q == '0 && !wr_ready_q) else $error("Partial clear left data");
  full_clear_a: assert property ((!full_reset_n)[*4] |=>
    read_data_out_q == '0 && !wr_ready_q) else $error("Full reset left data");
  reset_drive_a: assert property ((!(full_reset_n && partial_clear_n) &&
    !output_enable_n)[*4] |=> read_data_oe_q) else $error("Reset drive missing");
  oe_off_a: assert property (output_enable_n[*4] |=> !read_data_oe_q)
    else $error("Driven with output enable off");
  select_off_a: assert property ((read_select_n && full_reset_n && partial_clear_n)[*4]
    |=> !read_data_oe_q) else $error("Driven while deselected");
  select_on_a: assert property ((!read_select_n && !output_enable_n &&
    full_reset_n && partial_clear_n)[*4] |=> read_data_oe_q) else $error("Not driven");
  rewind_flag_a: assert property (rewind_s |-> ##[1:5] empty_flag_n_q == ft_q)
    else $error("Rewind flag missing");
  empty_hold_a: assert property ((!empty_flag_n_q && !ft_q && !read_clk_strobe &&
    full_reset_n && partial_clear_n)[*4] |=> $stable(read_data_out_q))
    else $error("Output moved while idle");
endmodule
`default_nettype wire

// ===== frp_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module frp_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire
